// File: logic/fut_pkg.sv
/*
  Shared constants and carrier types for the buffered serial port:
  register offsets, field positions, reset values and bit timing.
  Assumes a single synchronous clock domain; no other package is needed.
*/
package fut_pkg;

  // ------------------------------------------------------------------
  // Register offsets on the 3-bit host address
  // ------------------------------------------------------------------
  localparam logic [2:0] ADDR_DATA = 3'h0;  // holding regs / divisor low
  localparam logic [2:0] ADDR_IEN  = 3'h1;  // interrupt_enable / divisor_high
  localparam logic [2:0] ADDR_IST  = 3'h2;  // interrupt_status read, fifo_control write
  localparam logic [2:0] ADDR_LCT  = 3'h3;
  localparam logic [2:0] ADDR_MCT  = 3'h4;
  localparam logic [2:0] ADDR_LST  = 3'h5;
  localparam logic [2:0] ADDR_SPR  = 3'h7;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int unsigned FCT_ENABLE_BIT   = 0;
  localparam int unsigned FCT_RX_FLUSH_BIT = 1;
  localparam int unsigned FCT_TX_FLUSH_BIT = 2;
  localparam int unsigned MCT_PRESCALE_BIT = 7;
  localparam int unsigned IEN_RX_BIT       = 0;
  localparam int unsigned IEN_TX_BIT       = 1;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [15:0] DIV_RESET = 16'h0001;
  localparam logic [7:0]  LCT_RESET = 8'h03;
  localparam logic [7:0]  REG_RESET = 8'h00;

  // ------------------------------------------------------------------
  // Bit timing, in 16X ticks and input clocks
  // ------------------------------------------------------------------
  localparam logic [3:0] OVERSAMPLE_LAST  = 4'hF;  // 16 ticks per bit
  localparam logic [3:0] HALF_BIT_LAST    = 4'h7;  // 8 ticks to start centre
  localparam logic [1:0] PRESCALE_LAST    = 2'h3;  // divide by 4
  localparam int unsigned TIMEOUT_WORDS   = 4;
  localparam int unsigned TIMEOUT_EXTRA   = 12;
  localparam int unsigned MIN_WORD_BITS   = 5;
  localparam int unsigned TICKS_PER_BIT   = 16;

  // Interrupt identification codes
  localparam logic [3:0] IST_NONE    = 4'h1;
  localparam logic [3:0] IST_TX      = 4'h2;
  localparam logic [3:0] IST_RX      = 4'h4;
  localparam logic [3:0] IST_TIMEOUT = 4'hC;

  // ------------------------------------------------------------------
  // Carrier types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic       brk;
    logic       frame;
    logic       parity;
    logic [7:0] data;
  } fut_rx_entry_s;

  typedef struct packed {
    logic       dlab;
    logic       brk_ctl;
    logic       stick;
    logic       even;
    logic       par_en;
    logic       stop2;
    logic [1:0] wlen;
  } fut_lct_s;

endpackage

// File: logic/fut_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides and a fill count.
  Assumes one clock; flush empties it in one cycle.
*/
`timescale 1ns/1ps
module fut_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  // Clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       flush_i,
  // Fill side
  input  wire logic                       in_valid_i,
  output logic                            in_ready_o,
  input  wire logic [WIDTH-1:0]           in_data_i,
  // Drain side
  output logic                            out_valid_o,
  input  wire logic                       out_ready_i,
  output logic [WIDTH-1:0]                out_data_o,
  // Status
  output logic [$clog2(DEPTH+1)-1:0]      count_o
);
  localparam int unsigned AW = $clog2(DEPTH);

  // Pointer arithmetic wraps by bit width only
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("fut_fifo DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0]          mem_reg [DEPTH];
  logic [AW-1:0]             wr_ptr_reg;
  logic [AW-1:0]             rd_ptr_reg;
  logic [$clog2(DEPTH+1)-1:0] cnt_reg;
  logic                      push;
  logic                      pop;

  // ------------------------------------------------------------------
  // Handshakes
  // ------------------------------------------------------------------
  assign in_ready_o  = (cnt_reg != DEPTH[$clog2(DEPTH+1)-1:0]);
  assign out_valid_o = (cnt_reg != '0);
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_ready_i & out_valid_o;
  assign out_data_o  = mem_reg[rd_ptr_reg];
  assign count_o     = cnt_reg;

  // Storage, no reset needed on data
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk_i) begin
    if (rst_i || flush_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg    <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

endmodule // fut_fifo

// File: logic/fut_uart.sv
/*
  Serial port datapath: rate generator, transmitter and receiver with
  FIFOs, line status, interrupt status and receive timeout.
  Assumes host strobes and the receive line are synchronous to clk_i,
  and clk_i is the input clock that feeds the prescaler.
*/
//
// Behaviour
// - Input clock, divisor one: 16X tick per clock, or every fourth clock.
// - Divisor high/low bytes set clocks per 16X tick; zero acts as one.
// - Modem control bit 7 selects prescale by one or by four.
// - Every transmitted bit lasts exactly sixteen 16X ticks.
// - Frame is start, data bits, optional parity, then one or two stops.
// - Data bit zero goes out first after the start bit.
// - In FIFO mode each holding write pushes into the 16-entry FIFO; a write while it is full is dropped.
// - Without FIFO, holding-empty sets as the byte moves to the shifter.
// - Transmit empty interrupt shows in status bit 1 only if enabled.
// - Without FIFO, line status bit 6 sets when holding and shifter are both empty.
// - In FIFO mode line status bit 5 means transmit FIFO empty.
// - In FIFO mode transmit interrupt when level falls below trigger.
// - Line status bit 6 needs both FIFO and shifter empty.
// - Falling edge, wait eight ticks, keep start only if still low.
// - Data, parity, stop sampled mid-bit, sixteen ticks apart.
// - Receive FIFO holds 16 entries of data plus three error tags.
// - Holding read pops and error bits follow the new head.
// - Receive holding shows the oldest byte held.
// - Receive interrupt per byte, or at trigger level in FIFO mode.
// - Timeout after four word lengths plus twelve bits with data waiting.
`timescale 1ns/1ps
module fut_uart
  import fut_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = 16
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Host register port
  input  wire logic [2:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [7:0]       rdata_o,
  output logic             irq_o,
  // Serial line
  input  wire logic        rx_i,
  output logic             tx_o
);
  import fut_pkg::*;

  localparam int unsigned CW = $clog2(FIFO_DEPTH+1);
  if (FIFO_DEPTH != 16) begin : g_bad_depth
    $error("fut_uart trigger tables assume FIFO_DEPTH of 16");
  end

  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PARITY, ST_STOP} fut_state_e;

  // ------------------------------------------------------------------
  // Host registers
  // ------------------------------------------------------------------
  logic [15:0]   div_reg;
  logic [7:0]    ien_reg;
  logic [7:0]    fct_reg;
  fut_lct_s      lct_reg;
  logic [7:0]    mct_reg;
  logic [7:0]    spr_reg;
  logic          overrun_reg;
  logic          wr_data;
  logic          rd_data;
  logic          rd_lst;
  logic          fifo_en;
  logic [1:0]    flush;

  assign fifo_en = fct_reg[FCT_ENABLE_BIT];
  assign wr_data = wr_i && addr_i == ADDR_DATA && !lct_reg.dlab;
  assign rd_data = rd_i && addr_i == ADDR_DATA && !lct_reg.dlab;
  assign rd_lst  = rd_i && addr_i == ADDR_LST;

  // Control register writes; FIFO mode change also empties both FIFOs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_reg <= DIV_RESET;
      ien_reg <= REG_RESET;
      fct_reg <= REG_RESET;
      lct_reg <= LCT_RESET;
      mct_reg <= REG_RESET;
      spr_reg <= REG_RESET;
      flush   <= 2'b00;
    end else begin
      flush <= 2'b00;
      if (wr_i) begin
        case (addr_i)
          ADDR_DATA: if (lct_reg.dlab) div_reg[7:0] <= wdata_i;
          ADDR_IEN: begin
            if (lct_reg.dlab) div_reg[15:8] <= wdata_i;
            else ien_reg <= wdata_i;
          end
          ADDR_IST: begin
            fct_reg <= {wdata_i[7:3], 2'b00, wdata_i[0]};
            flush   <= {wdata_i[FCT_TX_FLUSH_BIT] | (wdata_i[0] ^ fifo_en),
                        wdata_i[FCT_RX_FLUSH_BIT] | (wdata_i[0] ^ fifo_en)};
          end
          ADDR_LCT: lct_reg <= wdata_i;
          ADDR_MCT: mct_reg <= wdata_i;
          ADDR_SPR: spr_reg <= wdata_i;
          default: ;
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // Rate generator: prescaler then divisor, one 16X tick pulse
  // ------------------------------------------------------------------
  logic [1:0]  pre_cnt_reg;
  logic [15:0] div_cnt_reg;
  logic        pre_tick;
  logic        tick;
  logic [15:0] div_last;

  assign pre_tick = !mct_reg[MCT_PRESCALE_BIT] || pre_cnt_reg == PRESCALE_LAST;
  assign div_last = (div_reg == 16'h0000) ? 16'h0000 : div_reg - 16'h0001;
  assign tick     = pre_tick && div_cnt_reg >= div_last;

  // Prescale and divisor counters
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_cnt_reg <= 2'h0;
      div_cnt_reg <= 16'h0000;
    end else begin
      pre_cnt_reg <= pre_tick ? 2'h0 : pre_cnt_reg + 2'h1;
      if (pre_tick) begin
        div_cnt_reg <= tick ? 16'h0000 : div_cnt_reg + 16'h0001;
      end
    end
  end

  // Word length helpers
  logic [7:0] wmask;
  logic [2:0] last_bit;
  assign last_bit = {1'b1, lct_reg.wlen};
  assign wmask    = 8'hFF >> (2'h3 - lct_reg.wlen);

  // ------------------------------------------------------------------
  // Transmit FIFO and shifter
  // ------------------------------------------------------------------
  logic          txf_ready;
  logic          txf_valid;
  logic [7:0]    txf_data;
  logic [CW-1:0] txf_count;
  logic          tx_take;
  fut_state_e    tx_state_reg;
  logic [3:0]    tx_tick_reg;
  logic [2:0]    tx_bit_reg;
  logic [7:0]    tx_sh_reg;
  logic          tx_par_reg;
  logic          tx_stop2_reg;
  logic          tx_bit_end;

  fut_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .flush_i     (flush[1]),
    // Non-FIFO mode behaves as a single holding byte
    .in_valid_i  (wr_data && (fifo_en || txf_count == '0)),
    .in_ready_o  (txf_ready),
    .in_data_i   (wdata_i),
    .out_valid_o (txf_valid),
    .out_ready_i (tx_take),
    .out_data_o  (txf_data),
    .count_o     (txf_count)
  );

  assign tx_take    = tx_state_reg == ST_IDLE;
  assign tx_bit_end = tick && tx_tick_reg == OVERSAMPLE_LAST;

  // Transmit sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_state_reg <= ST_IDLE;
      tx_tick_reg  <= 4'h0;
      tx_bit_reg   <= 3'h0;
      tx_sh_reg    <= 8'h00;
      tx_par_reg   <= 1'b0;
      tx_stop2_reg <= 1'b0;
    end else begin
      if (tick) begin
        tx_tick_reg <= tx_tick_reg + 4'h1;
      end
      case (tx_state_reg)
        ST_IDLE: if (txf_valid) begin
          tx_state_reg <= ST_START;
          tx_tick_reg  <= 4'h0;
          tx_bit_reg   <= 3'h0;
          tx_sh_reg    <= txf_data;
          tx_stop2_reg <= 1'b0;
          // Stick parity sends the inverse of the even select
          tx_par_reg   <= lct_reg.stick ? !lct_reg.even : (^(txf_data & wmask)) ^ !lct_reg.even;
        end
        ST_START: if (tx_bit_end) tx_state_reg <= ST_DATA;
        ST_DATA: if (tx_bit_end) begin
          tx_sh_reg  <= {1'b0, tx_sh_reg[7:1]};
          tx_bit_reg <= tx_bit_reg + 3'h1;
          if (tx_bit_reg == last_bit) begin
            tx_state_reg <= lct_reg.par_en ? ST_PARITY : ST_STOP;
          end
        end
        ST_PARITY: if (tx_bit_end) tx_state_reg <= ST_STOP;
        ST_STOP: if (tx_bit_end) begin
          if (lct_reg.stop2 && !tx_stop2_reg) begin
            tx_stop2_reg <= 1'b1;
          end else begin
            tx_state_reg <= ST_IDLE;
          end
        end
        default: tx_state_reg <= ST_IDLE;
      endcase
    end
  end

  // Line driver, registered; break control forces spacing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_o <= 1'b1;
    end else begin
      case (tx_state_reg)
        ST_START:  tx_o <= 1'b0;
        ST_DATA:   tx_o <= tx_sh_reg[0] & !lct_reg.brk_ctl;
        ST_PARITY: tx_o <= tx_par_reg & !lct_reg.brk_ctl;
        default:   tx_o <= !lct_reg.brk_ctl;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Receiver
  // ------------------------------------------------------------------
  fut_state_e    rx_state_reg;
  logic [3:0]    rx_tick_reg;
  logic [2:0]    rx_bit_reg;
  logic [7:0]    rx_sh_reg;
  logic          rx_prev_reg;
  logic          rx_perr_reg;
  logic          rx_push_reg;
  fut_rx_entry_s rx_entry_reg;
  logic          rx_mid;
  logic          rxf_ready;
  logic          rxf_valid;
  fut_rx_entry_s rxf_head;
  logic [CW-1:0] rxf_count;
  logic          rx_accept;

  assign rx_mid = tick && rx_tick_reg == OVERSAMPLE_LAST;

  // Start validation, mid-bit sampling and error tagging
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_state_reg <= ST_IDLE;
      rx_tick_reg  <= 4'h0;
      rx_bit_reg   <= 3'h0;
      rx_sh_reg    <= 8'h00;
      rx_prev_reg  <= 1'b1;
      rx_perr_reg  <= 1'b0;
      rx_push_reg  <= 1'b0;
      rx_entry_reg <= '0;
    end else begin
      rx_prev_reg <= rx_i;
      rx_push_reg <= 1'b0;
      if (tick) begin
        rx_tick_reg <= rx_tick_reg + 4'h1;
      end
      case (rx_state_reg)
        ST_IDLE: if (rx_prev_reg && !rx_i) begin
          rx_state_reg <= ST_START;
          rx_tick_reg  <= 4'h0;
        end
        ST_START: if (tick && rx_tick_reg == HALF_BIT_LAST) begin
          // False start returns to hunting; line noise builds no byte
          rx_state_reg <= rx_i ? ST_IDLE : ST_DATA;
          rx_tick_reg  <= 4'h0;
          rx_bit_reg   <= 3'h0;
          rx_sh_reg    <= 8'h00;
        end
        ST_DATA: if (rx_mid) begin
          rx_sh_reg[rx_bit_reg] <= rx_i;
          rx_bit_reg            <= rx_bit_reg + 3'h1;
          if (rx_bit_reg == last_bit) begin
            rx_state_reg <= lct_reg.par_en ? ST_PARITY : ST_STOP;
            rx_perr_reg  <= 1'b0;
          end
        end
        ST_PARITY: if (rx_mid) begin
          rx_state_reg <= ST_STOP;
          rx_perr_reg  <= lct_reg.stick ? (rx_i == lct_reg.even)
                                        : ((^rx_sh_reg) ^ rx_i ^ !lct_reg.even);
        end
        ST_STOP: if (rx_mid) begin
          // Leaving at mid stop gives half a bit to catch the next edge
          rx_state_reg        <= ST_IDLE;
          rx_push_reg         <= 1'b1;
          rx_entry_reg.data   <= rx_sh_reg;
          rx_entry_reg.parity <= rx_perr_reg;
          rx_entry_reg.frame  <= !rx_i;
          rx_entry_reg.brk    <= !rx_i && rx_sh_reg == 8'h00;
        end
        default: rx_state_reg <= ST_IDLE;
      endcase
    end
  end

  assign rx_accept = fifo_en || rxf_count == '0;

  fut_fifo #(.WIDTH($bits(fut_rx_entry_s)), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .flush_i     (flush[0]),
    .in_valid_i  (rx_push_reg && rx_accept),
    .in_ready_o  (rxf_ready),
    .in_data_i   (rx_entry_reg),
    .out_valid_o (rxf_valid),
    .out_ready_i (rd_data),
    .out_data_o  (rxf_head),
    .count_o     (rxf_count)
  );

  // Overrun: a lost byte wins over the clearing status read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      overrun_reg <= 1'b0;
    end else if (rx_push_reg && (!rxf_ready || !rx_accept)) begin
      overrun_reg <= 1'b1;
    end else if (rd_lst) begin
      overrun_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Receive timeout, counted in 16X ticks
  // ------------------------------------------------------------------
  logic [9:0] to_cnt_reg;
  logic [9:0] to_limit;
  logic       to_hit;

  assign to_limit = 10'((TIMEOUT_WORDS * (MIN_WORD_BITS + lct_reg.wlen) + TIMEOUT_EXTRA) * TICKS_PER_BIT);
  assign to_hit   = rxf_valid && to_cnt_reg >= to_limit;

  // Restarts on each arrival or holding read, and holds at zero while the FIFO is empty
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      to_cnt_reg <= 10'h000;
    end else if (rx_push_reg || rd_data || !rxf_valid) begin
      to_cnt_reg <= 10'h000;
    end else if (tick && !to_hit) begin
      to_cnt_reg <= to_cnt_reg + 10'h001;
    end
  end

  // ------------------------------------------------------------------
  // Status, interrupts and read data
  // ------------------------------------------------------------------
  logic [CW-1:0] rx_trig;
  logic [CW-1:0] tx_trig;
  logic          tx_empty;
  logic          shifter_empty;
  logic          tx_irq;
  logic          rx_irq;
  logic [7:0]    lst;
  logic [3:0]    ist_code;

  // Receive trigger 1/4/8/14, transmit trigger 16/8/4/1
  always_comb begin
    case (fct_reg[7:6])
      2'b00:   rx_trig = CW'(1);
      2'b01:   rx_trig = CW'(4);
      2'b10:   rx_trig = CW'(8);
      default: rx_trig = CW'(14);
    endcase
    case (fct_reg[5:4])
      2'b00:   tx_trig = CW'(16);
      2'b01:   tx_trig = CW'(8);
      2'b10:   tx_trig = CW'(4);
      default: tx_trig = CW'(1);
    endcase
  end

  assign tx_empty      = txf_count == '0;
  assign shifter_empty = tx_state_reg == ST_IDLE;
  assign tx_irq = ien_reg[IEN_TX_BIT] && (fifo_en ? txf_count < tx_trig : tx_empty);
  assign rx_irq = ien_reg[IEN_RX_BIT] && (fifo_en ? rxf_count >= rx_trig : rxf_valid);
  assign lst = {rxf_valid && (rxf_head.brk | rxf_head.frame | rxf_head.parity),
                tx_empty && shifter_empty,
                tx_empty,
                rxf_valid && rxf_head.brk,
                rxf_valid && rxf_head.frame,
                rxf_valid && rxf_head.parity,
                overrun_reg,
                rxf_valid};
  assign ist_code = (ien_reg[IEN_RX_BIT] && to_hit) ? IST_TIMEOUT :
                    rx_irq ? IST_RX : tx_irq ? IST_TX : IST_NONE;
  assign irq_o    = ist_code != IST_NONE;

  // Registered read data; holding read shows the oldest entry
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        ADDR_DATA: rdata_o <= lct_reg.dlab ? div_reg[7:0] : rxf_head.data;
        ADDR_IEN:  rdata_o <= lct_reg.dlab ? div_reg[15:8] : ien_reg;
        ADDR_IST:  rdata_o <= {{2{fifo_en}}, 2'b00, ist_code};
        ADDR_LCT:  rdata_o <= lct_reg;
        ADDR_MCT:  rdata_o <= mct_reg;
        ADDR_LST:  rdata_o <= lst;
        ADDR_SPR:  rdata_o <= spr_reg;
        default:   rdata_o <= 8'h00;
      endcase
    end
  end

endmodule // fut_uart

// File: dv/fut_uart_assertions.sv
/* Checker for the serial port top: line timing, status and reads.
   Assumes one clock; shadows the host writes that set the timing. */
`timescale 1ns/1ps
module fut_uart_chk
  import fut_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = 16
) (
  // Clock, reset and host port
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       irq_o,
  // Serial lines
  input wire logic       rx_i,
  input wire logic       tx_o
);
  logic [7:0] lct_reg, ien_reg, dvl_reg, dvh_reg, fcnt_reg;
  logic       pre_reg, tx_reg;
  wire        fast = !pre_reg && {dvh_reg, dvl_reg} == 16'h0001 && lct_reg[6:0] == 7'h03;
  wire        lst_rd = rd_i && addr_i == ADDR_LST;
  wire        ist_rd = rd_i && addr_i == ADDR_IST;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Shadow of timing and enable writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lct_reg <= LCT_RESET;
      ien_reg <= REG_RESET;
      {dvh_reg, dvl_reg} <= DIV_RESET;
      pre_reg <= 1'b0;
    end else if (wr_i) begin
      if (addr_i == ADDR_LCT) lct_reg <= wdata_i;
      if (addr_i == ADDR_MCT) pre_reg <= wdata_i[MCT_PRESCALE_BIT];
      if (addr_i == ADDR_DATA && lct_reg[7]) dvl_reg <= wdata_i;
      if (addr_i == ADDR_IEN && lct_reg[7]) dvh_reg <= wdata_i;
      if (addr_i == ADDR_IEN && !lct_reg[7]) ien_reg <= wdata_i;
    end
  end
  // Frame position; only 8N1 at one tick per clock, other modes unknown
  always_ff @(posedge clk_i) begin
    tx_reg <= tx_o;
    if (rst_i || !fast) fcnt_reg <= 8'h00;
    else if (fcnt_reg != 8'h00) fcnt_reg <= fcnt_reg - 8'h01;
    else if (tx_reg && !tx_o) fcnt_reg <= 8'h9F;
  end
  sequence s_hold15;
    $stable(tx_o)[*8] ##1 $stable(tx_o)[*7];
  endsequence
  a_bit_hold: assert property ($changed(tx_o) |=> s_hold15)
    else $error("tx bit too short");
  a_start_low: assert property (fcnt_reg >= 8'h91 |-> !tx_o)
    else $error("start bit not low");
  a_stop_high: assert property (fcnt_reg != 8'h00 && fcnt_reg <= 8'h10 |-> tx_o)
    else $error("stop bit not high");
  a_temt_busy: assert property (lst_rd && fcnt_reg > 8'h04 |=> !rdata_o[6])
    else $error("empty flag during frame");
  a_temt_thre: assert property (lst_rd |=> !rdata_o[6] || rdata_o[5])
    else $error("empty flag with data held");
  a_isr_irq: assert property (ist_rd |=> rdata_o[5:4] == 2'h0 && (rdata_o[3:0] != IST_NONE) == $past(irq_o))
    else $error("status code and irq disagree");
  a_irq_gate: assert property (ien_reg[1:0] == 2'h0 |-> !irq_o)
    else $error("irq while disabled");
  a_rdata_hold: assert property (!rd_i |=> $stable(rdata_o))
    else $error("read data moved");
endmodule // fut_uart_chk

bind fut_uart fut_uart_chk #(.FIFO_DEPTH(FIFO_DEPTH)) chk_u (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .rx_i(rx_i), .tx_o(tx_o));

// File: dv/fut_remote.sv
/* Remote serial device on the far side of the line pair.
   Assumes bit_clks input clocks per bit, set by the bench. */
`timescale 1ns/1ps
module fut_remote (
  // Clock and serial lines
  input  wire logic clk_i,
  input  wire logic tx_i,
  output logic      rx_o
);
  int         bit_clks = 16;
  logic [7:0] got_q[$];
  logic [7:0] b;
  initial rx_o = 1'b1;
  // One frame out; a low stop makes a framing fault
  task automatic send(input logic [7:0] d, input logic stop_v);
    logic [9:0] f;
    f = {stop_v, d, 1'b0};
    @(posedge clk_i);
    for (int i = 0; i < 10; i++) begin
      rx_o <= f[i];
      repeat (bit_clks) @(posedge clk_i);
    end
    rx_o <= 1'b1;
    repeat (bit_clks) @(posedge clk_i);
  endtask
  // Low pulse too short to pass as a start bit
  task automatic glitch();
    @(posedge clk_i);
    rx_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    rx_o <= 1'b1;
    repeat (32) @(posedge clk_i);
  endtask
  // Mid-bit decode; frames with a low stop are not kept
  initial forever begin
    @(negedge tx_i);
    repeat (bit_clks / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_clks) @(posedge clk_i);
      b[i] = tx_i;
    end
    repeat (bit_clks) @(posedge clk_i);
    if (tx_i) got_q.push_back(b);
  end
endmodule // fut_remote

// File: dv/test_fut_uart.sv
/* Bench for the serial port: host register cycles and a remote
   device on the serial lines. Assumes fut_pkg and fut_remote. */
`timescale 1ns/1ps
module test_fut_uart;
  import fut_pkg::*;
  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00;
  logic       wr_i = 1'b0;
  logic       rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic       irq_o, rx_i, tx_o;
  int         mismatches = 0;
  int         n_compared = 0;
  fut_uart dut_u (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .rx_i(rx_i), .tx_o(tx_o));
  fut_remote far_u (.clk_i(clk_i), .tx_i(tx_o), .rx_o(rx_i));
  // 40 MHz clock
  initial forever #12.5 clk_i = ~clk_i;
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic irq_is(input int n, input logic exp);
    repeat (n) @(posedge clk_i);
    #1 check({7'h00, irq_o}, {7'h00, exp});
  endtask
  // Strobes rise after one edge and are taken at the next
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 check(rdata_o, exp);
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Bounded wait for frames at the far side
  task automatic wait_rx(input int n);
    int k;
    for (k = 0; k < 9000 && far_u.got_q.size() < n; k++) @(posedge clk_i);
    if (k == 9000) begin
      mismatches++;
      complete_run();
    end
    repeat (64) @(posedge clk_i);
  endtask
  task automatic t_reset();
    rd(ADDR_LST, 8'h60);
    rd(ADDR_IST, 8'h01);
    rd(3'h6, 8'h00);
    $display("t_reset done");
  endtask
  // Single byte: holding empties at once, shifter after the stop
  task automatic t_tx_single();
    wr(ADDR_IEN, 8'h02);
    wr(ADDR_DATA, 8'hA5);
    rd(ADDR_LST, 8'h20);
    rd(ADDR_IST, 8'h02);
    wait_rx(1);
    check(far_u.got_q[0], 8'hA5);
    rd(ADDR_LST, 8'h60);
    wr(ADDR_IEN, 8'h00);
    $display("t_tx_single done");
  endtask
  // Eighteen writes: one to the shifter, sixteen queued, last dropped
  task automatic t_tx_fifo();
    far_u.got_q.delete();
    wr(ADDR_IST, 8'h31);
    wr(ADDR_IEN, 8'h02);
    for (int i = 0; i < 18; i++) wr(ADDR_DATA, 8'h40 + i[7:0]);
    rd(ADDR_LST, 8'h00);
    irq_is(0, 1'b0);
    wait_rx(17);
    for (int i = 0; i < 17; i++) check(far_u.got_q[i], 8'h40 + i[7:0]);
    rd(ADDR_LST, 8'h60);
    rd(ADDR_IST, 8'hC2);
    wr(ADDR_IEN, 8'h00);
    irq_is(0, 1'b0);
    $display("t_tx_fifo done");
  endtask
  // False start, error tag at the head, trigger at four, timeout
  task automatic t_rx();
    wr(ADDR_IST, 8'h41);
    wr(ADDR_IEN, 8'h01);
    far_u.glitch();
    rd(ADDR_LST, 8'h60);
    far_u.send(8'h3C, 1'b0);
    far_u.send(8'h11, 1'b1);
    far_u.send(8'h22, 1'b1);
    irq_is(0, 1'b0);
    far_u.send(8'h33, 1'b1);
    rd(ADDR_IST, 8'hC4);
    rd(ADDR_LST, 8'hE9);
    rd(ADDR_DATA, 8'h3C);
    rd(ADDR_LST, 8'h61);
    rd(ADDR_DATA, 8'h11);
    irq_is(690, 1'b0);
    irq_is(30, 1'b1);
    rd(ADDR_IST, 8'hCC);
    $display("t_rx done");
  endtask
  // Prescale by four, then divisor two, decoded at the far side
  task automatic t_rate();
    far_u.got_q.delete();
    wr(ADDR_MCT, 8'h80);
    far_u.bit_clks = 64;
    wr(ADDR_DATA, 8'h5A);
    wait_rx(1);
    wr(ADDR_MCT, 8'h00);
    wr(ADDR_LCT, 8'h83);
    wr(ADDR_DATA, 8'h02);
    wr(ADDR_IEN, 8'h00);
    wr(ADDR_LCT, 8'h03);
    far_u.bit_clks = 32;
    wr(ADDR_DATA, 8'hC3);
    wait_rx(2);
    check(far_u.got_q[0], 8'h5A);
    check(far_u.got_q[1], 8'hC3);
    $display("t_rate done");
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_tx_single();
    t_tx_fifo();
    t_rx();
    t_rate();
    complete_run();
  end
endmodule // test_fut_uart
